// File: design/abpc_consts.svh
// constants of the adapter bulk property command block
//
// Notes on behaviour
// - batched update result is 0x0000, 0x0011 or 0xFFFF; others are undefined.
// - length field counts payload bytes only, no header or check byte.
// - adapter answers a notification and broadcasts the flagged property codes.
// - get-service and set-service notifications overwrite the adapter's stored values.
// - notification response uses 0xA2, echoes sequence, length 0x0002, two-byte result.
// - result 0x0000 ok, 0x0011 network down, 0x0012 rejected, 0xFFFF other.
// - forbidden mode answers 0x0101, 0x0103, 0x0104 or 0x0105 by adapter state.
// - adapter decodes object access read or write and answers with matching response.
// - command error reply to batched update makes adapter fall back to single requests.
// - bad check, unknown command, undefined result or malformed frame gets error frame.
`ifndef ABPC_CONSTS_SVH
`define ABPC_CONSTS_SVH

// ==========================================================
// frame layout
`define ABPC_STX          8'h02
`define ABPC_FT_CMD       16'h0003
`define ABPC_FT_ERR       16'h00FF
`define ABPC_HDR_LEN      17'h00006
`define ABPC_PAY_MAX      16'h0040
`define ABPC_OBJ_HDR      7'h04
`define ABPC_NTF_HDR      7'h05
`define ABPC_RES_LEN      16'h0002

// ==========================================================
// command and error numbers
`define ABPC_CN_BATCH_RSP 8'hA1
`define ABPC_CN_NTF_REQ   8'h22
`define ABPC_CN_NTF_RSP   8'hA2
`define ABPC_CN_OBJ_REQ   8'h23
`define ABPC_CN_OBJ_RSP   8'hA3
`define ABPC_ERR_FCC      8'h00
`define ABPC_ERR_CMD      8'h01
`define ABPC_ERR_RESULT   8'h02
`define ABPC_ERR_FRAME    8'h03
`define ABPC_TYPE_WR      8'h01
`define ABPC_NTF_TYPE_MAX 8'h03

// ==========================================================
// result codes
`define ABPC_RES_OK       16'h0000
`define ABPC_RES_ABSENT   16'h0011
`define ABPC_RES_NET_DOWN 16'h0011
`define ABPC_RES_REJECT   16'h0012
`define ABPC_RES_OTHER    16'hFFFF
`define ABPC_RES_UNCONF   16'h0101
`define ABPC_RES_STANDBY  16'h0103
`define ABPC_RES_CONSTR   16'h0104
`define ABPC_RES_ERRSTOP  16'h0105

// ==========================================================
// adapter modes held in the control register
`define ABPC_MODE_OPER    3'h0
`define ABPC_MODE_UNCONF  3'h1
`define ABPC_MODE_STANDBY 3'h3
`define ABPC_MODE_CONSTR  3'h4
`define ABPC_MODE_ERRSTOP 3'h5

// ==========================================================
// register map and fields
`define ABPC_OFS_CTRL     8'h00
`define ABPC_OFS_STATUS   8'h04
`define ABPC_OFS_CLEAR    8'h08
`define ABPC_OFS_ENABLE   8'h0C
`define ABPC_OFS_RESULT   8'h10
`define ABPC_OFS_STORE    8'h14
`define ABPC_CTRL_RESET   5'h00
`define ABPC_CTRL_NET     3
`define ABPC_CTRL_REJ     4
`define ABPC_EV_NTF       0
`define ABPC_EV_OBJ       1
`define ABPC_EV_ERR       2
`define ABPC_EV_FALLBACK  3
`define ABPC_EV_BATCH     4

`endif

// File: design/abpc_pkg.sv
// types of the adapter bulk property command block
package abpc_pkg;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_RX    = 7'h02,
		ST_DRAIN = 7'h04,
		ST_EXEC  = 7'h08,
		ST_SCAN  = 7'h10,
		ST_ANN   = 7'h20,
		ST_TX    = 7'h40
	} abpc_state_type;

	typedef struct packed {
		logic       last;
		logic [7:0] data;
	} abpc_byte_type;

	typedef struct packed {
		abpc_state_type   st;
		logic [16:0]      idx;
		logic [15:0]      ft;
		logic [7:0]       cn;
		logic [7:0]       fn;
		logic [15:0]      dl;
		logic [7:0]       fcc;
		logic             fcc_bad;
		logic             bad;
		logic [63:0][7:0] pay;
		logic [63:0][7:0] store;
		logic [6:0]       store_len;
		logic [6:0]       k;
		logic [6:0]       ann_idx;
		logic [6:0]       ann_end;
		logic             ann_valid;
		logic [7:0]       ann_code;
		logic [15:0]      tx_ft;
		logic [7:0]       tx_cn;
		logic [15:0]      tx_dl;
		logic [15:0]      tx_res;
		logic [7:0]       tx_idx;
		logic [7:0]       tx_byte;
		logic [7:0]       tx_fcc;
		logic             tx_valid;
		logic             fallback;
		logic [4:0]       ctrl;
		logic [4:0]       ien;
		logic [4:0]       sts;
		logic [7:0]       last_cn;
		logic [15:0]      last_res;
		logic [31:0]      rdata;
	} abpc_regs_type;

endpackage : abpc_pkg

// File: design/abpc_core.sv
// adapter side command handler for bulk property frames
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`include "abpc_consts.svh"

module abpc_core (
	// clock and reset
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_reset_n,
	// received byte stream from the serial link
	input  wire logic                   i_rx_valid,
	input  wire abpc_pkg::abpc_byte_type i_rx,
	// transmitted byte stream to the serial link
	output logic                        o_tx_valid,
	output logic [7:0]                  o_tx_data,
	input  wire logic                   i_tx_ready,
	// property codes to announce on the network
	output logic                        o_ann_valid,
	output logic [7:0]                  o_ann_code,
	input  wire logic                   i_ann_ready,
	// batched update request tracking
	input  wire logic                   i_batch_pending,
	output logic                        o_fallback,
	// register port
	input  wire logic [7:0]             i_addr,
	input  wire logic [31:0]            i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic [31:0]                 o_rdata,
	// interrupt
	output logic                        o_irq
);

	abpc_pkg::abpc_regs_type r;
	abpc_pkg::abpc_regs_type n;

	// ==========================================================
	// combinational locals
	logic [4:0]  ev;
	logic        go_tx;
	logic        do_err;
	logic [7:0]  err_code;
	logic [7:0]  t_cn;
	logic [15:0] t_res;
	logic [6:0]  t_x;
	logic        do_copy;
	logic [6:0]  vlen;
	logic [16:0] pos;
	logic        is_chk;
	logic [15:0] mode_res;
	logic [15:0] res;
	logic [7:0]  ni;
	logic [7:0]  nf;
	logic [7:0]  nb;
	logic [7:0]  tp;
	logic [7:0]  scan_byte;

	// ==========================================================
	// outputs
	assign o_tx_valid  = r.tx_valid;
	assign o_tx_data   = r.tx_byte;
	assign o_ann_valid = r.ann_valid;
	assign o_ann_code  = r.ann_code;
	assign o_fallback  = r.fallback;
	assign o_rdata     = r.rdata;
	assign o_irq       = |(r.sts & r.ien);

	// ==========================================================
	// next state
	always_comb begin
		n         = r;
		ev        = '0;
		go_tx     = 1'b0;
		do_err    = 1'b0;
		err_code  = `ABPC_ERR_FRAME;
		t_cn      = '0;
		t_res     = `ABPC_RES_OK;
		t_x       = '0;
		do_copy   = 1'b0;
		vlen      = '0;
		res       = `ABPC_RES_OK;
		pos       = r.idx - `ABPC_HDR_LEN;
		is_chk    = (r.idx >= `ABPC_HDR_LEN) &&
		            (r.idx == {1'b0, r.dl} + `ABPC_HDR_LEN);
		tp        = r.pay[0];
		scan_byte = r.pay[6'(r.dl[6:0] - 7'h01 - r.k)];
		ni        = r.tx_idx + 8'h01;
		nf        = r.tx_fcc;
		nb        = '0;
		n.fallback = 1'b0;
		n.rdata    = '0;
		// states that forbid service answer with a code of their own
		unique case (r.ctrl[2:0])
			`ABPC_MODE_OPER:    mode_res = `ABPC_RES_OK;
			`ABPC_MODE_UNCONF:  mode_res = `ABPC_RES_UNCONF;
			`ABPC_MODE_STANDBY: mode_res = `ABPC_RES_STANDBY;
			`ABPC_MODE_CONSTR:  mode_res = `ABPC_RES_CONSTR;
			`ABPC_MODE_ERRSTOP: mode_res = `ABPC_RES_ERRSTOP;
			default:            mode_res = `ABPC_RES_OTHER;
		endcase

		unique case (r.st)
			abpc_pkg::ST_IDLE: begin
				if (i_rx_valid && !i_rx.last && i_rx.data == `ABPC_STX) begin
					n.st      = abpc_pkg::ST_RX;
					n.idx     = '0;
					n.fcc     = '0;
					n.fcc_bad = 1'b0;
					n.bad     = 1'b0;
					n.dl      = '0;
				end
			end
			abpc_pkg::ST_RX: begin
				if (i_rx_valid) begin
					n.idx = r.idx + 17'h00001;
					if (is_chk) begin
						n.fcc_bad = (r.fcc != i_rx.data);
						// check byte must close the frame
						n.bad = !i_rx.last;
						n.st  = i_rx.last ? abpc_pkg::ST_EXEC :
						                    abpc_pkg::ST_DRAIN;
					end else begin
						n.fcc = r.fcc ^ i_rx.data;
						unique case (r.idx)
							17'h00000: n.ft[15:8] = i_rx.data;
							17'h00001: n.ft[7:0]  = i_rx.data;
							17'h00002: n.cn       = i_rx.data;
							17'h00003: n.fn       = i_rx.data;
							17'h00004: n.dl[15:8] = i_rx.data;
							17'h00005: n.dl[7:0]  = i_rx.data;
							default: ;
						endcase
						if (r.idx >= `ABPC_HDR_LEN && pos < 17'h00040)
							n.pay[pos[5:0]] = i_rx.data;
						// frame ended short of its length field
						if (i_rx.last) begin
							n.bad = 1'b1;
							n.st  = abpc_pkg::ST_EXEC;
						end
					end
				end
			end
			abpc_pkg::ST_DRAIN: begin
				if (i_rx_valid && i_rx.last)
					n.st = abpc_pkg::ST_EXEC;
			end
			abpc_pkg::ST_EXEC: begin
				n.st      = abpc_pkg::ST_IDLE;
				n.last_cn = r.cn;
				if (r.bad || r.dl > `ABPC_PAY_MAX) begin
					do_err = 1'b1;
				end else if (r.fcc_bad) begin
					do_err   = 1'b1;
					err_code = `ABPC_ERR_FCC;
				end else if (r.ft == `ABPC_FT_ERR) begin
					if (r.cn == `ABPC_ERR_CMD && i_batch_pending) begin
						n.fallback               = 1'b1;
						ev[`ABPC_EV_FALLBACK]    = 1'b1;
					end
				end else if (r.ft != `ABPC_FT_CMD) begin
					do_err = 1'b1;
				end else begin
					case (r.cn)
						`ABPC_CN_BATCH_RSP: begin
							res = {r.pay[0], r.pay[1]};
							if (r.dl < `ABPC_RES_LEN) begin
								do_err = 1'b1;
							end else if (res == `ABPC_RES_OK ||
							             res == `ABPC_RES_ABSENT ||
							             res == `ABPC_RES_OTHER) begin
								n.last_res           = res;
								ev[`ABPC_EV_BATCH]   = 1'b1;
							end else begin
								do_err   = 1'b1;
								err_code = `ABPC_ERR_RESULT;
							end
						end
						`ABPC_CN_NTF_REQ: begin
							if (r.dl[6:0] < `ABPC_NTF_HDR) begin
								do_err = 1'b1;
							end else begin
								if (mode_res != `ABPC_RES_OK)
									res = mode_res;
								else if (tp > `ABPC_NTF_TYPE_MAX)
									res = `ABPC_RES_OTHER;
								else if (!r.ctrl[`ABPC_CTRL_NET])
									res = `ABPC_RES_NET_DOWN;
								else if (r.ctrl[`ABPC_CTRL_REJ])
									res = `ABPC_RES_REJECT;
								n.last_res = res;
								if (res == `ABPC_RES_OK) begin
									n.st = abpc_pkg::ST_SCAN;
									n.k  = '0;
								end else begin
									go_tx = 1'b1;
									t_cn  = `ABPC_CN_NTF_RSP;
									t_res = res;
								end
							end
						end
						`ABPC_CN_OBJ_REQ: begin
							if (r.dl[6:0] < `ABPC_OBJ_HDR) begin
								do_err = 1'b1;
							end else begin
								if (mode_res != `ABPC_RES_OK)
									res = mode_res;
								else if (tp > `ABPC_TYPE_WR)
									res = `ABPC_RES_OTHER;
								n.last_res       = res;
								ev[`ABPC_EV_OBJ] = 1'b1;
								go_tx            = 1'b1;
								t_cn             = `ABPC_CN_OBJ_RSP;
								t_res            = res;
								if (res == `ABPC_RES_OK && tp == `ABPC_TYPE_WR) begin
									do_copy = 1'b1;
									vlen    = r.dl[6:0] - `ABPC_OBJ_HDR;
								end else if (res == `ABPC_RES_OK) begin
									t_x = r.store_len;
								end
							end
						end
						default: begin
							do_err   = 1'b1;
							err_code = `ABPC_ERR_CMD;
						end
					endcase
				end
			end
			abpc_pkg::ST_SCAN: begin
				// smallest count that matches its own code list wins
				if (r.k + `ABPC_NTF_HDR > r.dl[6:0]) begin
					n.st   = abpc_pkg::ST_IDLE;
					do_err = 1'b1;
				end else if (scan_byte == {1'b0, r.k}) begin
					ev[`ABPC_EV_NTF] = 1'b1;
					vlen      = r.dl[6:0] - r.k - `ABPC_NTF_HDR;
					do_copy   = (tp <= `ABPC_TYPE_WR);
					n.ann_idx = r.dl[6:0] - r.k;
					n.ann_end = r.dl[6:0];
					if (r.k == '0) begin
						n.st  = abpc_pkg::ST_IDLE;
						go_tx = 1'b1;
						t_cn  = `ABPC_CN_NTF_RSP;
					end else begin
						n.st        = abpc_pkg::ST_ANN;
						n.ann_valid = 1'b1;
						n.ann_code  = r.pay[6'(r.dl[6:0] - r.k)];
					end
				end else begin
					n.k = r.k + 7'h01;
				end
			end
			abpc_pkg::ST_ANN: begin
				if (i_ann_ready) begin
					n.ann_idx  = r.ann_idx + 7'h01;
					n.ann_code = r.pay[6'(r.ann_idx + 7'h01)];
					if (r.ann_idx + 7'h01 == r.ann_end) begin
						n.ann_valid = 1'b0;
						n.st        = abpc_pkg::ST_IDLE;
						go_tx       = 1'b1;
						t_cn        = `ABPC_CN_NTF_RSP;
					end
				end
			end
			abpc_pkg::ST_TX: begin
				if (i_tx_ready) begin
					if (r.tx_idx != 8'h00)
						nf = r.tx_fcc ^ r.tx_byte;
					unique case (ni)
						8'h01: nb = r.tx_ft[15:8];
						8'h02: nb = r.tx_ft[7:0];
						8'h03: nb = r.tx_cn;
						8'h04: nb = r.fn;
						8'h05: nb = r.tx_dl[15:8];
						8'h06: nb = r.tx_dl[7:0];
						8'h07: nb = (r.tx_dl == '0) ? nf : r.tx_res[15:8];
						8'h08: nb = r.tx_res[7:0];
						default: nb = (ni == r.tx_dl[7:0] + 8'h07) ? nf :
						              r.store[6'(ni - 8'h09)];
					endcase
					n.tx_fcc  = nf;
					n.tx_idx  = ni;
					n.tx_byte = nb;
					// the check byte has just been taken
					if (r.tx_idx == r.tx_dl[7:0] + 8'h07) begin
						n.tx_valid = 1'b0;
						n.st       = abpc_pkg::ST_IDLE;
					end
				end
			end
			default: n.st = abpc_pkg::ST_IDLE;
		endcase

		// ======================================================
		// value store overwrite
		if (do_copy) begin
			n.store_len = vlen;
			for (int j = 0; j < 64; j++) begin
				if (7'(j) < vlen)
					n.store[j] = r.pay[6'(j + 4)];
			end
		end

		// ======================================================
		// frame launch: response or error frame
		if (do_err) begin
			ev[`ABPC_EV_ERR] = 1'b1;
			n.tx_ft  = `ABPC_FT_ERR;
			n.tx_cn  = err_code;
			n.tx_dl  = '0;
		end else if (go_tx) begin
			n.tx_ft  = `ABPC_FT_CMD;
			n.tx_cn  = t_cn;
			n.tx_res = t_res;
			n.tx_dl  = `ABPC_RES_LEN + {9'h000, t_x};
		end
		if (do_err || go_tx) begin
			n.st       = abpc_pkg::ST_TX;
			n.tx_idx   = '0;
			n.tx_fcc   = '0;
			n.tx_byte  = `ABPC_STX;
			n.tx_valid = 1'b1;
		end

		// ======================================================
		// register port; a new event wins over a clear
		if (i_wr) begin
			unique case (i_addr)
				`ABPC_OFS_CTRL:   n.ctrl = i_wdata[4:0];
				`ABPC_OFS_ENABLE: n.ien  = i_wdata[4:0];
				default: ;
			endcase
		end
		n.sts = r.sts;
		if (i_wr && i_addr == `ABPC_OFS_CLEAR)
			n.sts = r.sts & ~i_wdata[4:0];
		n.sts = n.sts | ev;
		if (i_rd) begin
			unique case (i_addr)
				`ABPC_OFS_CTRL:   n.rdata = {27'h0000000, r.ctrl};
				`ABPC_OFS_STATUS: n.rdata = {27'h0000000, r.sts};
				`ABPC_OFS_ENABLE: n.rdata = {27'h0000000, r.ien};
				`ABPC_OFS_RESULT: n.rdata = {8'h00, r.last_cn, r.last_res};
				`ABPC_OFS_STORE:  n.rdata = {25'h0000000, r.store_len};
				default:          n.rdata = '0;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			r      <= '0;
			r.st   <= abpc_pkg::ST_IDLE;
			r.ctrl <= `ABPC_CTRL_RESET;
		end else begin
			r <= n;
		end
	end

endmodule : abpc_core

// File: tb/abpc_checker.sv
// port assertions of the adapter bulk property command block
`timescale 1ns/1ns
module abpc_checker (
	// clock and reset
	input wire logic                    i_clk_sys,
	input wire logic                    i_reset_n,
	// link
	input wire logic                    i_rx_valid,
	input wire abpc_pkg::abpc_byte_type i_rx,
	input wire logic                    o_tx_valid,
	input wire logic [7:0]              o_tx_data,
	input wire logic                    i_tx_ready,
	input wire logic                    o_ann_valid,
	input wire logic [7:0]              o_ann_code,
	input wire logic                    i_ann_ready,
	input wire logic                    i_batch_pending,
	input wire logic                    o_fallback,
	// registers
	input wire logic [7:0]              i_addr,
	input wire logic [31:0]             i_wdata,
	input wire logic                    i_wr,
	input wire logic                    i_rd,
	input wire logic [31:0]             o_rdata,
	input wire logic                    o_irq
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	// ==========================================================
	// checks
	a_rdata_idle:
		assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data outside read slot");
	a_tx_hold:
		assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid
			&& $stable(o_tx_data)) else $error("tx byte dropped");
	a_ann_hold:
		assert property (o_ann_valid && !i_ann_ready |=> o_ann_valid
			&& $stable(o_ann_code)) else $error("announce dropped");
	a_ann_before_tx:
		assert property (o_ann_valid |-> !o_tx_valid)
		else $error("announce overlaps response");
	a_tx_start_byte:
		assert property ($rose(o_tx_valid) |-> o_tx_data == 8'h02)
		else $error("response without start byte");
	a_fallback_pulse:
		assert property (o_fallback |=> !o_fallback)
		else $error("fallback longer than one cycle");
	a_fallback_cause:
		assert property (o_fallback |-> $past(i_rx_valid && i_rx.last, 2)
			&& $past(i_batch_pending, 2)) else $error("fallback uncaused");
	a_irq_masked:
		assert property (i_wr && i_addr == 8'h0C && i_wdata[4:0] == 5'h00
			|-> ##2 !o_irq) else $error("irq while all masked");
endmodule : abpc_checker

bind abpc_core abpc_checker abpc_checker_i (.i_clk_sys(i_clk_sys),
	.i_reset_n(i_reset_n), .i_rx_valid(i_rx_valid), .i_rx(i_rx),
	.o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready),
	.o_ann_valid(o_ann_valid), .o_ann_code(o_ann_code),
	.i_ann_ready(i_ann_ready), .i_batch_pending(i_batch_pending),
	.o_fallback(o_fallback), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));

// File: tb/abpc_appliance.sv
// appliance controller model on the adapter serial link
`timescale 1ns/1ns
module abpc_appliance (
	// clock
	input  wire logic                    i_clk_sys,
	// frames to the adapter
	output abpc_pkg::abpc_byte_type      o_rx,
	output logic                         o_rx_valid,
	// frames from the adapter
	input  wire logic                    i_tx_valid,
	input  wire logic [7:0]              i_tx_data,
	output logic                         o_tx_ready,
	input  wire logic                    i_slow
);
	logic [7:0] rsp[$];
	logic       tog = 1'b0;
	initial begin
		o_rx = '{1'b0, 8'h5A};
		o_rx_valid = 1'b0;
		o_tx_ready = 1'b1;
	end
	// slow mode takes a byte only every other cycle to stress the hold path
	always @(posedge i_clk_sys) begin
		tog <= ~tog;
		o_tx_ready <= !i_slow || tog;
		if (i_tx_valid && o_tx_ready)
			rsp.push_back(i_tx_data);
	end
	function automatic logic done();
		return rsp.size() >= 7 && rsp.size() == 8 + {rsp[5], rsp[6]};
	endfunction : done
	task automatic send(input logic [15:0] ft, input logic [7:0] cn, fn,
		input logic [7:0] pay[$], input logic [15:0] dl, input logic bad);
		logic [7:0] f[$];
		logic [7:0] x;
		f = {ft[15:8], ft[7:0], cn, fn, dl[15:8], dl[7:0], pay};
		x = 8'h00;
		foreach (f[i]) x ^= f[i];
		f.push_back(x ^ {7'h0, bad});
		f.push_front(8'h02);
		foreach (f[i]) begin
			@(posedge i_clk_sys);
			o_rx_valid <= 1'b1;
			o_rx <= '{i == f.size() - 1, f[i]};
		end
		@(posedge i_clk_sys);
		o_rx_valid <= 1'b0;
		// released line shows the inverse, never the last byte
		o_rx <= '{1'b0, ~x};
	endtask : send
endmodule : abpc_appliance

// File: tb/tb_adapter_bulk_property_commands.sv
// self-checking bench of the adapter bulk property command block
`timescale 1ns/1ns
module tb_adapter_bulk_property_commands;
	logic                    i_clk_sys = 1'b0;
	logic                    i_reset_n = 1'b0;
	logic                    i_rx_valid, i_tx_ready, o_tx_valid;
	abpc_pkg::abpc_byte_type i_rx;
	logic [7:0]              o_tx_data, o_ann_code, ann_last, x;
	logic                    o_ann_valid, o_fallback, o_irq, slow = 1'b0;
	logic                    i_ann_ready = 1'b0, i_batch_pending = 1'b0;
	logic [7:0]              i_addr = 8'h00;
	logic [31:0]             i_wdata = 32'h0, o_rdata;
	logic                    i_wr = 1'b0, i_rd = 1'b0;
	int                      fails = 0, checks = 0, anns = 0, fbs = 0;
	logic [7:0]              pay[$];
	logic [63:0]             r;
	// ctrl, command, type, answer command, length, result, flags
	// flags: 0 announce, 1 silent, 2 pending, 4 bad check, 5 short
	logic [63:0]             rows[23] = '{
		64'h08_22_00_A2_02_0000_01, 64'h00_22_00_A2_02_0011_00,
		64'h18_22_00_A2_02_0012_00, 64'h09_22_00_A2_02_0101_00,
		64'h0B_22_00_A2_02_0103_00, 64'h0C_22_00_A2_02_0104_00,
		64'h0D_22_00_A2_02_0105_00, 64'h08_22_04_A2_02_FFFF_00,
		64'h08_22_01_A2_02_0000_01, 64'h08_22_02_A2_02_0000_01,
		64'h08_22_03_A2_02_0000_01, 64'h08_23_00_A3_04_0000_00,
		64'h08_23_01_A3_02_0000_00, 64'h08_23_00_A3_03_0000_00,
		64'h08_23_02_A3_02_FFFF_00, 64'h0C_23_00_A3_02_0104_00,
		64'h08_55_00_01_00_0000_00, 64'h08_22_00_00_00_0000_10,
		64'h08_22_00_03_00_0000_20, 64'h08_A1_05_02_00_0000_00,
		64'h08_A1_00_00_00_0000_02, 64'h08_A1_11_00_00_0000_02,
		64'h08_01_00_00_00_0000_06};

	abpc_core abpc_core_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
		.i_rx_valid(i_rx_valid), .i_rx(i_rx), .o_tx_valid(o_tx_valid),
		.o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready),
		.o_ann_valid(o_ann_valid), .o_ann_code(o_ann_code),
		.i_ann_ready(i_ann_ready), .i_batch_pending(i_batch_pending),
		.o_fallback(o_fallback), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));
	abpc_appliance abpc_appliance_i (.i_clk_sys(i_clk_sys), .o_rx(i_rx),
		.o_rx_valid(i_rx_valid), .i_tx_valid(o_tx_valid),
		.i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready), .i_slow(slow));

	// ==========================================================
	// clock, announce sink, watchdog
	initial forever #4 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) begin
		i_ann_ready <= ~i_ann_ready;
		if (o_ann_valid && i_ann_ready) begin
			anns++;
			ann_last <= o_ann_code;
		end
		if (o_fallback)
			fbs++;
	end
	initial begin
		repeat (60000) @(posedge i_clk_sys);
		fails++;
		$display("unexpected run length expected end seen watchdog");
		results();
	end

	// ==========================================================
	// tasks
	task automatic cmp(input string nm, input logic [15:0] e, g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clk_sys);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1;
		checks++;
		if (o_rdata !== e) begin
			fails++;
			$display("unexpected register %h expected %h seen %h", a, e, o_rdata);
		end
	endtask : rd
	task automatic check_rsp(input logic [7:0] fn);
		logic [7:0] q[$];
		q = abpc_appliance_i.rsp;
		cmp("answer complete", 16'h1, 16'(abpc_appliance_i.done()));
		if (!abpc_appliance_i.done())
			return;
		x = 8'h00;
		for (int i = 1; i < q.size() - 1; i++) x ^= q[i];
		cmp("frame type", r[39] ? 16'h0003 : 16'h00FF, {q[1], q[2]});
		cmp("command", 16'(r[39:32]), 16'(q[3]));
		cmp("sequence", 16'(fn), 16'(q[4]));
		cmp("length", 16'(r[31:24]), {q[5], q[6]});
		cmp("check byte", 16'(x), 16'(q[q.size() - 1]));
		if (r[31:24] != 8'h00)
			cmp("result", r[23:8], {q[7], q[8]});
		if (r[31:24] > 8'h02)
			cmp("value", r[25] ? 16'h00CC : 16'h00AA, 16'(q[9]));
	endtask : check_rsp
	task automatic results;
		if (fails == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	// ==========================================================
	// main sequence
	initial begin
		repeat (8) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h0C, 32'h0);
		rd(8'h20, 32'h0);
		foreach (rows[n]) begin
			r = rows[n];
			wr(8'h00, {24'h0, r[63:56]});
			i_batch_pending <= r[2];
			slow <= n[0];
			anns = 0;
			abpc_appliance_i.rsp.delete();
			case (r[55:48])
				8'h22: pay = {r[47:40], 8'h01, 8'h02, 8'h03, 8'hAA, 8'hBB, 8'h01, 8'h80};
				8'h23: pay = {r[47:40], 8'h01, 8'h02, 8'h03};
				8'h01: pay = {};
				// type field carries the low result byte of a batched answer
				8'hA1: begin
					pay = {8'h00, r[47:40]};
					if (r[47:40] == 8'h00)
						pay = {8'h00, 8'h00, 8'h00, 8'h00};
				end
				default: pay = {8'h00, 8'h05};
			endcase
			if (r[55:48] == 8'h23 && r[47:40] == 8'h01)
				pay.push_back(8'hCC);
			abpc_appliance_i.send(r[55:48] == 8'h01 ? 16'h00FF : 16'h0003,
				r[55:48], n[7:0], pay, 16'(pay.size()) + 16'(r[5]), r[4]);
			if (r[1]) begin
				repeat (20) @(posedge i_clk_sys);
				cmp("answer bytes", 16'h0, 16'(abpc_appliance_i.rsp.size()));
			end else begin
				repeat (3000) if (!abpc_appliance_i.done()) @(posedge i_clk_sys);
				check_rsp(n[7:0]);
			end
			cmp("announced", 16'(r[0]), 16'(anns));
			if (r[0])
				cmp("announce code", 16'h0080, 16'(ann_last));
		end
		cmp("fallback", 16'h1, 16'(fbs));
		rd(8'h04, 32'h1F);
		rd(8'h10, 32'h0001_0011);
		wr(8'h0C, 32'h08);
		repeat (2) @(posedge i_clk_sys);
		cmp("irq", 16'h1, 16'(o_irq));
		wr(8'h08, 32'h08);
		wr(8'h04, 32'h0);
		rd(8'h04, 32'h17);
		cmp("irq", 16'h0, 16'(o_irq));
		rd(8'h0C, 32'h08);
		wr(8'h0C, 32'h0);
		rd(8'h14, 32'h1);
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		rd(8'h00, 32'h0);
		results();
	end
endmodule : tb_adapter_bulk_property_commands
